// >>> verilog/ids_top.sv
`timescale 1ns/1ps
`include "ids_defs.svh"

module ids_top
    import ids_pkg::*;
#(
    parameter bit EXT_BUS = 1'b1,
    parameter int ADDR_W = 8
)
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST,
    // Register port.
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Outgoing messages.
    output logic MSG_VALID,
    output ids_msg_s MSG,
    // Incoming messages from other units.
    input wire logic IN_VALID,
    input wire ids_msg_s IN_MSG,
    // Acceptance results.
    output logic ACCEPT,
    output logic ACC_ARB,
    output logic SELF_HIT,
    output ids_acc_s ACC
);

    // The offsets need eight address bits; a narrower port cannot decode them.
    if (ADDR_W < 8)
    begin : g_bad_addr
        $error("ADDR_W must be at least 8");
    end

    logic [31:0] cmd_lo;
    logic [31:0] cmd_hi;
    logic [31:0] ldest;
    logic [31:0] dfmt;
    logic [7:0] lid;
    logic [3:0] last_flags;
    logic [7:0] acc_count;
    logic lo_wr;
    logic [2:0] w_dlv;
    logic [1:0] w_sh;
    logic w_lvl;
    logic w_trg;
    logic old_lvl_drop;
    logic old_deassert;
    logic next_send;
    logic next_self;
    ids_msg_s next_msg;
    logic [7:0] bcast;
    logic [3:0] model;
    logic own_src;
    logic phys_hit;
    logic flat_hit;
    logic clus_hit;
    logic next_accept;

    assign lo_wr = WR && (ADDR[7:0] == `IDS_OFF_CMD_LO);
    assign w_dlv = WDATA[`IDS_CMD_DLV];
    assign w_sh = WDATA[`IDS_CMD_SH];
    assign w_lvl = WDATA[`IDS_CMD_LEVEL];
    assign w_trg = WDATA[`IDS_CMD_TRIG];
    assign bcast = EXT_BUS ? `IDS_BCAST_EXT : {4'h0, `IDS_BCAST_OLD};

    // Software-held registers; the command low word is captured on the same write that sends.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            cmd_lo <= `IDS_ZERO32;
            cmd_hi <= `IDS_ZERO32;
            ldest <= `IDS_ZERO32;
            dfmt <= `IDS_DFMT_RST;
            lid <= 8'h00;
        end
        else if (WR)
        begin
            unique case (ADDR[7:0])
                `IDS_OFF_CMD_LO: cmd_lo <= WDATA;
                `IDS_OFF_CMD_HI: cmd_hi <= WDATA;
                `IDS_OFF_LDEST: ldest <= WDATA;
                `IDS_OFF_DFMT: dfmt <= WDATA;
                `IDS_OFF_LID: lid <= WDATA[7:0];
                default: ;
            endcase
        end
    end

    // Older-bus level handling. Invalid combinations are not trapped; they are software's
    // responsibility and simply pass through as edge messages.
    assign old_lvl_drop = !EXT_BUS && w_trg && !w_lvl
        && (w_dlv == `IDS_DLV_FIXED || w_dlv == `IDS_DLV_LOWEST
        || w_dlv == `IDS_DLV_NMI);
    assign old_deassert = !EXT_BUS && w_trg && !w_lvl && (w_dlv == `IDS_DLV_INIT);

    // Build the outgoing message from the word being written.
    always_comb
    begin
        next_msg = '0;
        next_msg.vec = WDATA[`IDS_CMD_VEC];
        next_msg.dlv = w_dlv;
        next_msg.src = lid;
        // Only the deassert keeps level semantics; everything else is forced to edge.
        next_msg.trig = old_deassert;
        next_msg.level = !old_deassert;
        // Shorthand wins over the destination field and mode bit.
        if (w_sh == `IDS_SH_NONE)
        begin
            next_msg.logical = WDATA[`IDS_CMD_DMODE];
            if (EXT_BUS || WDATA[`IDS_CMD_DMODE])
            begin
                next_msg.dest = cmd_hi[`IDS_HI_DEST];
            end
            else
            begin
                next_msg.dest = {4'h0, cmd_hi[27:24]};
            end
        end
        else
        begin
            next_msg.logical = 1'b0;
            next_msg.dest = bcast;
            next_msg.excl_self = (w_sh == `IDS_SH_OTHERS);
        end
    end

    // Self delivery is done internally rather than by snooping the bus.
    assign next_send = lo_wr && !old_lvl_drop && (w_sh != `IDS_SH_SELF);
    assign next_self = lo_wr && !old_lvl_drop
        && (w_sh == `IDS_SH_SELF || w_sh == `IDS_SH_ALL);

    // Message output stage.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            MSG_VALID <= 1'b0;
            MSG <= '0;
            SELF_HIT <= 1'b0;
        end
        else
        begin
            MSG_VALID <= next_send;
            SELF_HIT <= next_self;
            if (lo_wr)
            begin
                MSG <= next_msg;
            end
        end
    end

    // Receive-side match terms.
    assign model = dfmt[`IDS_DF_MODEL];
    assign own_src = IN_MSG.excl_self && (IN_MSG.src == lid);
    assign phys_hit = EXT_BUS
        ? (IN_MSG.dest == lid || IN_MSG.dest == `IDS_BCAST_EXT)
        : (IN_MSG.dest[3:0] == lid[3:0] || IN_MSG.dest[3:0] == `IDS_BCAST_OLD);
    assign flat_hit = (model == `IDS_MODEL_FLAT)
        && |(IN_MSG.dest & ldest[`IDS_LD_ID]);
    assign clus_hit = (model == `IDS_MODEL_CLUS)
        && (IN_MSG.dest == `IDS_BCAST_EXT || (IN_MSG.dest[7:4] == ldest[`IDS_LD_CLUS]
        && |(IN_MSG.dest[3:0] & ldest[`IDS_LD_MEMB])));
    assign next_accept = IN_VALID && !own_src
        && (IN_MSG.logical ? (flat_hit || clus_hit) : phys_hit);

    // Acceptance output; lowest-priority hits are only candidates for arbitration.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ACCEPT <= 1'b0;
            ACC_ARB <= 1'b0;
            ACC <= '0;
        end
        else
        begin
            ACCEPT <= next_accept;
            ACC_ARB <= next_accept && (IN_MSG.dlv == `IDS_DLV_LOWEST);
            if (next_accept)
            begin
                ACC <= '{vec: IN_MSG.vec, dlv: IN_MSG.dlv, trig: IN_MSG.trig,
                    level: IN_MSG.level};
            end
        end
    end

    // Status of the last command and a wrapping count of accepted messages.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            last_flags <= 4'h0;
            acc_count <= 8'h00;
        end
        else
        begin
            if (lo_wr)
            begin
                last_flags <= {next_self, next_send, old_deassert, old_lvl_drop};
            end
            if (next_accept)
            begin
                acc_count <= acc_count + 8'h01;
            end
        end
    end

    // Read data stand only in the cycle after the read strobe; unmapped reads return zero.
    always_ff @(posedge CLK)
    begin
        if (RST || !RD)
        begin
            RDATA <= `IDS_ZERO32;
        end
        else
        begin
            unique case (ADDR[7:0])
                `IDS_OFF_CMD_LO: RDATA <= cmd_lo;
                `IDS_OFF_CMD_HI: RDATA <= cmd_hi;
                `IDS_OFF_LDEST: RDATA <= ldest;
                `IDS_OFF_DFMT: RDATA <= dfmt;
                `IDS_OFF_LID: RDATA <= {24'h000000, lid};
                `IDS_OFF_STAT: RDATA <= {16'h0000, acc_count, 4'h0, last_flags};
                default: RDATA <= `IDS_ZERO32;
            endcase
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    sequence cmd_write;
        lo_wr;
    endsequence

    sequence old_level_cmd;
        cmd_write and (!EXT_BUS && w_trg);
    endsequence

    sequence in_phys_self;
        IN_VALID && !IN_MSG.logical && !IN_MSG.excl_self && IN_MSG.dest == lid;
    endsequence

    level_drop_a: assert property (old_level_cmd ##0 (!w_lvl && w_dlv == `IDS_DLV_FIXED
        && w_sh == `IDS_SH_NONE) |=> !MSG_VALID && !SELF_HIT)
        else $error("dropped level command still sent");

    init_deassert_a: assert property (old_level_cmd ##0 (!w_lvl && w_dlv == `IDS_DLV_INIT
        && w_sh == `IDS_SH_NONE) |=> MSG_VALID && MSG.trig && !MSG.level)
        else $error("init deassert not sent as level deassert");

    edge_override_a: assert property (cmd_write ##0 (w_trg && w_lvl && w_sh != `IDS_SH_SELF)
        |=> MSG_VALID && !MSG.trig)
        else $error("level command not turned into edge");

    self_only_a: assert property (cmd_write ##0 (w_sh == `IDS_SH_SELF && w_trg == 1'b0)
        |=> SELF_HIT && !MSG_VALID)
        else $error("self shorthand reached the bus");

    short_bcast_a: assert property (cmd_write ##0 (w_sh != `IDS_SH_NONE)
        |=> !MSG.logical && MSG.dest == bcast)
        else $error("shorthand message not physical broadcast");

    mode_follow_a: assert property (cmd_write ##0 (w_sh == `IDS_SH_NONE)
        |=> MSG.logical == $past(WDATA[`IDS_CMD_DMODE]))
        else $error("destination mode not carried");

    phys_accept_a: assert property (in_phys_self |=> ACCEPT ##0 ACC.vec == $past(IN_MSG.vec))
        else $error("own physical message not accepted");

    flat_accept_a: assert property (IN_VALID && IN_MSG.logical && !IN_MSG.excl_self
        && model == `IDS_MODEL_FLAT |=> ACCEPT == $past(|(IN_MSG.dest & ldest[`IDS_LD_ID])))
        else $error("flat model match wrong");

    arb_flag_a: assert property (next_accept && IN_MSG.dlv == `IDS_DLV_LOWEST
        |=> ACCEPT && ACC_ARB)
        else $error("lowest priority hit not flagged for arbitration");

    bad_model_a: assert property (IN_VALID && IN_MSG.logical
        && model != `IDS_MODEL_FLAT && model != `IDS_MODEL_CLUS |=> !ACCEPT)
        else $error("logical accept with unknown model");

    // An incoming message that is not excluded by its own sender.
    sequence in_clean;
        IN_VALID && !IN_MSG.excl_self;
    endsequence

    // Read data must fall back to zero so a stale word is never taken twice.
    rdata_idle_a: assert property (!RD |=> RDATA == `IDS_ZERO32)
        else $error("read data stands without a read");

    // Nothing leaves the unit unless the command low word was written.
    msg_needs_write_a: assert property (!lo_wr |=> !MSG_VALID && !SELF_HIT)
        else $error("message sent without command write");

    // All-including-self reaches both the bus and this unit.
    all_self_a: assert property (cmd_write ##0 (w_sh == `IDS_SH_ALL && !old_lvl_drop)
        |=> SELF_HIT && MSG_VALID)
        else $error("all including self not delivered both ways");

    // All-excluding-self goes out marked so the sender drops its own copy.
    others_excl_a: assert property (cmd_write ##0 (w_sh == `IDS_SH_OTHERS && !old_lvl_drop)
        |=> MSG_VALID && MSG.excl_self && !SELF_HIT)
        else $error("all excluding self not marked");

    // The older bus carries only four physical destination bits.
    old_phys_a: assert property (cmd_write ##0 (!EXT_BUS && w_sh == `IDS_SH_NONE
        && !WDATA[`IDS_CMD_DMODE]) |=> MSG.dest[7:4] == 4'h0)
        else $error("older bus physical destination too wide");

    // Without shorthand the extended bus copies the whole destination field.
    dest_carry_a: assert property (cmd_write ##0 (EXT_BUS && w_sh == `IDS_SH_NONE)
        |=> MSG.dest == $past(cmd_hi[`IDS_HI_DEST]))
        else $error("destination field not carried");

    // The sender is named so receivers can drop their own excluded copy.
    src_carry_a: assert property (cmd_write |=> MSG.src == $past(lid))
        else $error("sender id not carried");

    // A message the sender excluded itself from must never be taken back.
    own_drop_a: assert property (IN_VALID && IN_MSG.excl_self && IN_MSG.src == lid
        |=> !ACCEPT)
        else $error("excluded sender accepted own message");

    // Extended-bus physical broadcast reaches every unit.
    ext_bcast_a: assert property (in_clean ##0 (EXT_BUS && !IN_MSG.logical
        && IN_MSG.dest == `IDS_BCAST_EXT) |=> ACCEPT)
        else $error("extended broadcast not accepted");

    // Older-bus physical broadcast looks at the low nibble only.
    old_bcast_a: assert property (in_clean ##0 (!EXT_BUS && !IN_MSG.logical
        && IN_MSG.dest[3:0] == `IDS_BCAST_OLD) |=> ACCEPT)
        else $error("older broadcast not accepted");

    // An all-ones address hits every cluster and every member.
    clus_bcast_a: assert property (in_clean ##0 (IN_MSG.logical && model == `IDS_MODEL_CLUS
        && IN_MSG.dest == `IDS_BCAST_EXT) |=> ACCEPT)
        else $error("cluster broadcast not accepted");

    // The arbitration flag is only ever a qualifier of an acceptance.
    arb_only_a: assert property (ACC_ARB |-> ACCEPT)
        else $error("arbitration flag without acceptance");

endmodule

// >>> verilog/ids_defs.svh
// Summary of operation
// - Older bus: level fixed, lowest or NMI command goes edge if level bit set, else dropped.
// - Older bus: level INIT goes edge if level bit set, else as INIT deassert.
// - Destination mode bit picks physical or logical addressing per message.
// - Destination field carries a physical identifier or a logical address.
// - Shorthand addresses all, all but sender, or sender only, ignoring destination.
// - Lowest-priority delivery only flags each accepting unit as an arbitration candidate (ACC_ARB); no arbitration is done.
// - Extended bus: physical 00 to FE is one unit, FF is broadcast.
// - Older bus: physical 0 to E is one unit, F is broadcast.
// - Logical message accepted only when address matches logical and format registers.
// - Logical destination register holds an 8-bit logical identifier field.
// - Format register holds a 4-bit model field choosing flat or cluster.
// - Model 1111 selects flat: each unit owns one identifier bit.
// - Flat model accepts when address AND logical identifier is nonzero.
// - Model 0000 selects the cluster interpretation.
// - With any shorthand the destination mode bit is ignored.
// - Writing the command low word builds and sends a message.
`ifndef IDS_DEFS_SVH
`define IDS_DEFS_SVH

// Register byte offsets.
`define IDS_OFF_CMD_LO 8'h00
`define IDS_OFF_CMD_HI 8'h04
`define IDS_OFF_LDEST 8'h08
`define IDS_OFF_DFMT 8'h0C
`define IDS_OFF_LID 8'h10
`define IDS_OFF_STAT 8'h14

// Command word, logical destination and format register fields.
`define IDS_CMD_VEC 7:0
`define IDS_CMD_DLV 10:8
`define IDS_CMD_DMODE 11
`define IDS_CMD_LEVEL 14
`define IDS_CMD_TRIG 15
`define IDS_CMD_SH 19:18
`define IDS_HI_DEST 31:24
`define IDS_LD_ID 31:24
`define IDS_LD_CLUS 31:28
`define IDS_LD_MEMB 27:24
`define IDS_DF_MODEL 31:28

// Delivery mode codes.
`define IDS_DLV_FIXED 3'h0
`define IDS_DLV_LOWEST 3'h1
`define IDS_DLV_SMI 3'h2
`define IDS_DLV_NMI 3'h4
`define IDS_DLV_INIT 3'h5

// Shorthand codes.
`define IDS_SH_NONE 2'h0
`define IDS_SH_SELF 2'h1
`define IDS_SH_ALL 2'h2
`define IDS_SH_OTHERS 2'h3

// Model codes, broadcast values and reset values.
`define IDS_MODEL_FLAT 4'hF
`define IDS_MODEL_CLUS 4'h0
`define IDS_BCAST_EXT 8'hFF
`define IDS_BCAST_OLD 4'hF
`define IDS_DFMT_RST 32'hFFFFFFFF
`define IDS_ZERO32 32'h00000000

`endif

// >>> verilog/ids_pkg.sv
package ids_pkg;

    // One interrupt message as it travels on the shared bus.
    typedef struct packed {
        logic [7:0] dest;
        logic logical;
        logic [2:0] dlv;
        logic [7:0] vec;
        logic level;
        logic trig;
        logic excl_self;
        logic [7:0] src;
    } ids_msg_s;

    // What this unit accepted.
    typedef struct packed {
        logic [7:0] vec;
        logic [2:0] dlv;
        logic trig;
        logic level;
    } ids_acc_s;

endpackage

// >>> bench/ids_peer.sv
`timescale 1ns/1ps

module ids_peer
    import ids_pkg::*;
#(
    parameter logic [7:0] PEER_ID = 8'h09
)
(
    // Clock.
    input wire logic clk,
    // Traffic from the unit under test.
    input wire logic msg_valid,
    input wire ids_msg_s msg,
    output logic hit,
    // Traffic towards the unit under test.
    output logic in_valid,
    output ids_msg_s in_msg
);
    // A physical message reaches this peer on its own id or on the broadcast value.
    always_ff @(posedge clk)
    begin
        hit <= msg_valid && !msg.logical
            && (msg.dest == PEER_ID || msg.dest == 8'hFF);
    end

    // The bus is idle at time zero.
    initial
    begin
        in_valid = 1'b0;
        in_msg = '0;
    end

    // Sends one valid edge command, level bit set; the vector echoes the destination.
    task automatic send(input logic [7:0] d, input logic lg, input logic [2:0] dl,
                        input logic ex, input logic [7:0] s);
        ids_msg_s m;
        m = '{dest: d, logical: lg, dlv: dl, vec: d, level: 1'b1, trig: 1'b0,
              excl_self: ex, src: s};
        @(posedge clk);
        in_valid <= 1'b1;
        in_msg <= m;
        @(posedge clk);
        in_valid <= 1'b0;
        // Released fields show the inverse so stale values never match by luck.
        in_msg <= ~m;
    endtask
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
`include "ids_defs.svh"

module testbench
    import ids_pkg::*;
;
    logic clk, rst, wr_en, rd_en, msg_valid, accept, acc_arb, self_hit, in_valid, hit;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, got;
    ids_msg_s msg, in_msg;
    ids_acc_s acc;
    logic old_valid, old_self, old_acc;
    ids_msg_s old_msg;
    int error_cnt = 0;
    int comparisons = 0;

    // Free running clock at 250 MHz.
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ids_top #(.EXT_BUS(1'b1), .ADDR_W(8)) i_dut (.CLK(clk), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr_en), .RD(rd_en), .RDATA(rdata), .MSG_VALID(msg_valid),
        .MSG(msg), .IN_VALID(in_valid), .IN_MSG(in_msg), .ACCEPT(accept),
        .ACC_ARB(acc_arb), .SELF_HIT(self_hit), .ACC(acc));

    // Older-bus unit on the same register port and the same incoming traffic.
    ids_top #(.EXT_BUS(1'b0), .ADDR_W(8)) i_old (.CLK(clk), .RST(rst), .ADDR(addr),
        .WDATA(wdata), .WR(wr_en), .RD(rd_en), .RDATA(), .MSG_VALID(old_valid),
        .MSG(old_msg), .IN_VALID(in_valid), .IN_MSG(in_msg), .ACCEPT(old_acc),
        .ACC_ARB(), .SELF_HIT(old_self), .ACC());

    ids_peer #(.PEER_ID(8'h09)) i_peer (.clk(clk), .msg_valid(msg_valid), .msg(msg),
        .hit(hit), .in_valid(in_valid), .in_msg(in_msg));

    task automatic give_verdict;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Register writes and reads take one strobe cycle; read data land in the next cycle.
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [7:0] a);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        got = rdata;
    endtask

    // Issues a command and checks the message, the self hit and the peer's view of it.
    task automatic cmd(input logic [31:0] hi, input logic [31:0] lo, input logic v,
                       input logic sh, input logic [7:0] d, input logic ex, input logic ph);
        ids_msg_s e;
        e = '{dest: d, logical: lo[11] && lo[19:18] == 2'h0, dlv: lo[10:8], vec: lo[7:0],
              level: 1'b1, trig: 1'b0, excl_self: ex, src: 8'h03};
        bus_wr(`IDS_OFF_CMD_HI, hi);
        bus_wr(`IDS_OFF_CMD_LO, lo);
        check({msg_valid, self_hit}, {v, sh});
        if (v)
            check({1'b0, msg}, {1'b0, e});
        @(posedge clk);
        #1;
        check(hit, ph);
    endtask

    // Presents one incoming message and checks acceptance one cycle later.
    task automatic rx(input logic [7:0] d, input logic lg, input logic [2:0] dl,
                      input logic ex, input logic [7:0] s, input logic ok);
        i_peer.send(d, lg, dl, ex, s);
        #1;
        check({accept, acc_arb}, {ok, ok && dl == `IDS_DLV_LOWEST});
        if (ok)
            check({1'b0, acc}, {d, dl, 1'b0, 1'b1});
    endtask

    task automatic t_regs;
        check({msg_valid, accept, acc_arb, self_hit}, 4'h0);
        bus_rd(`IDS_OFF_DFMT);
        check(got, `IDS_DFMT_RST);
        bus_rd(`IDS_OFF_LDEST);
        check(got, 32'h00000000);
        bus_wr(`IDS_OFF_LDEST, 32'hA5000000);
        bus_rd(`IDS_OFF_LDEST);
        check(got, 32'hA5000000);
        bus_rd(8'h40);
        check(got, 32'h00000000);
    endtask

    task automatic t_send;
        bus_wr(`IDS_OFF_LID, 32'h00000003);
        cmd(32'h09000000, 32'h00004031, 1, 0, 8'h09, 0, 1);
        cmd(32'h0C000000, 32'h00004942, 1, 0, 8'h0C, 0, 0);
        cmd(32'h0C000000, 32'h0000C050, 1, 0, 8'h0C, 0, 0);
        cmd(32'h0C000000, 32'h00084860, 1, 1, 8'hFF, 0, 1);
        cmd(32'h0C000000, 32'h000C4470, 1, 0, 8'hFF, 1, 1);
        cmd(32'h0C000000, 32'h00044080, 0, 1, 8'h00, 0, 0);
    endtask

    task automatic t_recv;
        bus_wr(`IDS_OFF_LDEST, 32'h04000000);
        rx(8'h03, 0, 0, 0, 8'h07, 1);
        rx(8'h04, 0, 0, 0, 8'h07, 0);
        rx(8'hFF, 0, 0, 0, 8'h07, 1);
        rx(8'hFF, 0, 0, 1, 8'h03, 0);
        rx(8'hFF, 0, 4, 1, 8'h07, 1);
        rx(8'h0C, 1, 0, 0, 8'h07, 1);
        rx(8'h03, 1, 0, 0, 8'h07, 0);
        rx(8'h04, 1, 1, 0, 8'h07, 1);
        bus_wr(`IDS_OFF_DFMT, 32'h0FFFFFFF);
        bus_wr(`IDS_OFF_LDEST, 32'h32000000);
        rx(8'h36, 1, 0, 0, 8'h07, 1);
        rx(8'h31, 1, 0, 0, 8'h07, 0);
        rx(8'h42, 1, 0, 0, 8'h07, 0);
        bus_wr(`IDS_OFF_DFMT, 32'h5FFFFFFF);
        rx(8'h36, 1, 0, 0, 8'h07, 0);
    endtask

    // Older-bus command: checks the pulse, destination and trigger handling.
    task automatic ocmd(input logic [31:0] hi, input logic [31:0] lo, input logic v,
                        input logic [7:0] d, input logic t);
        bus_wr(`IDS_OFF_CMD_HI, hi);
        bus_wr(`IDS_OFF_CMD_LO, lo);
        check({old_valid, old_self}, {v, 1'b0});
        if (v)
            check({old_msg.dest, old_msg.trig, old_msg.level}, {d, t, !t});
    endtask

    task automatic t_old;
        ocmd(32'h0C000000, 32'h00008031, 0, 8'h0C, 0);
        ocmd(32'h0C000000, 32'h00008530, 1, 8'h0C, 1);
        ocmd(32'h0C000000, 32'h0000C031, 1, 8'h0C, 0);
        ocmd(32'hF3000000, 32'h00004031, 1, 8'h03, 0);
        ocmd(32'h0C000000, 32'h000C4031, 1, 8'h0F, 0);
        i_peer.send(8'h1F, 0, 0, 0, 8'h07);
        #1;
        check({old_acc, accept}, 2'b10);
    endtask

    // Bounded watchdog so a hang ends in the verdict.
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end

    // Reset for two cycles, then the scenarios in turn.
    initial
    begin
        rst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 32'h00000000;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_send();
        t_recv();
        t_old();
        give_verdict();
    end
endmodule
